// File: inc/ldm_consts.svh
`ifndef LDM_CONSTS_SVH
`define LDM_CONSTS_SVH
// Register indices; the APB byte address is four times the index.
`define LDM_IDX_CONFIG0   8'h00
`define LDM_IDX_CONFIG1   8'h01
`define LDM_IDX_LEDCFG0   8'h02
`define LDM_IDX_RESET     8'h30
`define LDM_IDX_STATUS    8'h31
// Reset values.
`define LDM_RST_CHIP_EN   1'h0
`define LDM_RST_CONFIG1   6'h3C
`define LDM_SWRESET_KEY   8'hFF
// Field positions.
`define LDM_BIT_CHIP_EN   6
`define LDM_BIT_LOG       5
`define LDM_BIT_PSAVE     4
`define LDM_BIT_AUTOINC   3
`define LDM_BIT_DITHER    2
`define LDM_BIT_MAXCUR    1
`define LDM_BIT_GOFF      0
// Serial slave addresses.
`define LDM_ADDR_BASE     5'h0A
`define LDM_ADDR_BCAST    7'h3C
// Full-scale current levels in microamps.
`define LDM_IMAX_LO_UA    16'h639C
`define LDM_IMAX_HI_UA    16'h88B8
// Timing.
`define LDM_CLK_HZ        32'h0131_2D00
`define LDM_PSAVE_IDLE_MS 30
`endif

// File: inc/ldm_pkg.sv
`default_nettype none
package ldm_pkg;
  typedef enum logic [5:0] {
    LDM_SHUTDOWN = 6'h01,
    LDM_INIT     = 6'h02,
    LDM_STANDBY  = 6'h04,
    LDM_NORMAL   = 6'h08,
    LDM_PSAVE    = 6'h10,
    LDM_THERMAL  = 6'h20
  } ldm_mode_e;
  typedef enum logic [4:0] {
    LDM_I_IDLE = 5'h01,
    LDM_I_ADDR = 5'h02,
    LDM_I_REG  = 5'h04,
    LDM_I_WR   = 5'h08,
    LDM_I_RD   = 5'h10
  } ldm_i2c_e;
endpackage
`default_nettype wire

// File: core/ldm_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ldm_sync #(
  parameter int W = 1
) (
  // Clock and control.
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] stage1;

  // Two flip-flops; only the second stage reads the first.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      q      <= '0;
    end else if (ce) begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: core/ldm_idle_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ldm_idle_timer #(
  parameter int CYCLES = 600001,
  parameter int W      = 20
) (
  // Clock and control.
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Run while idle; done once the interval has fully elapsed.
  input  wire logic run,
  output var  logic done
);
  logic [W-1:0] cnt;

  // Refuse intervals the counter cannot hold.
  if (CYCLES < 1 || CYCLES >= (2 ** W)) begin : gChk
    $error("idle interval does not fit the counter");
  end

  // Counts idle cycles and restarts whenever the run condition drops.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt  <= '0;
      done <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt  <= '0; // [R23]
        done <= 1'b0;
      end else if (cnt == W'(CYCLES - 1)) begin
        done <= 1'b1;
      end else begin
        cnt <= cnt + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// File: core/ldm_mode_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
`include "ldm_consts.svh"
//
// Functional notes
// [R1] Channel n: bank n mod 3, module n/3.
// [R2] Small variant has channels 0 to 17 only.
// [R3] Max-current bit picks 25.5 or 35 mA.
// [R4] Idle outputs beyond 30 ms enter power-save.
// [R5] Power-save enable resets to one.
// [R6] Power-save: analog off, registers kept and accessible.
// [R7] Serial command in power-save returns to normal.
// [R8] Overtemperature shuts outputs; cooling resumes normal.
// [R9] Undervoltage holds reset and initialization state.
// [R10] Enable pin high enters initialization, registers default.
// [R11] Reset key write or undervoltage forces initialization.
// [R12] Chip-enable set enters normal, outputs driven.
// [R13] Power-up or enable low enters shutdown.
// [R14] Chip-enable clear: standby, outputs off, registers kept.
// [R15] Data changes only while serial clock low.
// [R16] Start is data fall, stop data rise, clock high.
// [R17] Only the master makes start and stop.
// [R18] Repeated start handled like a first start.
// [R19] Answer pin-set address and broadcast address.
// [R20] Eight bits MSB first, then acknowledge slot.
// [R21] Write: address, register index, then data.
// [R22] Register index auto-increments unless disabled.
// [R23] Idle counter restarts on activity or disable.
module ldm_mode_ctrl #(
  parameter int NCH          = 24,
  parameter int PSAVE_CYCLES = `LDM_PSAVE_IDLE_MS * (`LDM_CLK_HZ / 1000) + 1
) (
  // Clock, reset and clock enable.
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // APB register slave.
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  // Two-wire serial port pins.
  input  wire logic              scl,
  input  wire logic              sdaIn,
  output var  logic              sdaOut,
  output var  logic              sdaOutEn_n,
  // Device pins and analog flags.
  input  wire logic              enPin,
  input  wire logic              undervoltageLockout,
  input  wire logic              overTemp,
  input  wire logic              addressPinLow,
  input  wire logic              addressPinHigh,
  // Output activity from the PWM datapath.
  input  wire logic [NCH-1:0]    chanActive,
  // Mode and channel control.
  output var  logic [5:0]        mode,
  output var  logic              coreReset,
  output var  logic              analogOn,
  output var  logic              outEnable,
  output var  logic              maxCurrentHigh,
  output var  logic [15:0]       fullScaleUa,
  output var  logic              logScale,
  output var  logic              ditherOn,
  output var  logic [NCH-1:0]    moduleGroupSelect,
  output var  logic [2*NCH-1:0]  chanBank
);
  localparam int NG = NCH / 3;

  // Only the 18- and 24-channel variants exist.
  if (NCH != 18 && NCH != 24) begin : gChk
    $error("channel count must be 18 or 24"); // [R2]
  end

  ldm_pkg::ldm_mode_e state;
  ldm_pkg::ldm_mode_e next_state;
  ldm_pkg::ldm_i2c_e  iState;
  logic [6:0]         pinS;
  logic               sclS;
  logic               sdaS;
  logic               enS;
  logic               uvloS;
  logic               otS;
  logic               sclPrev;
  logic               sdaPrev;
  logic               startCond;
  logic               stopCond;
  logic               sclRise;
  logic               sclFall;
  logic               chipEn;
  logic [5:0]         cfg1;
  logic [NG-1:0]      ledCfg;
  logic               wrEn;
  logic [7:0]         wrIdx;
  logic [7:0]         wrData;
  logic               apbWr;
  logic               swReset;
  logic               clearRegs;
  logic [7:0]         apbIdx;
  logic               apbMapped;
  logic [3:0]         bitCnt;
  logic [7:0]         shift;
  logic [7:0]         regIdx;
  logic [7:0]         nextIdx;
  logic [7:0]         rdByte;
  logic               rw;
  logic               mAck;
  logic               cmdSeen;
  logic               addrMatch;
  logic               wrSet;
  logic               i2cWrPend;
  logic [7:0]         i2cWrIdx;
  logic [7:0]         i2cWrData;
  logic               idleDone;
  logic [NCH-1:0]     grpSel;
  logic [2*NCH-1:0]   bankCode;

  // Register read decode, shared by APB and the serial port.
  function automatic logic [7:0] rd_reg(input logic [7:0] idx);
    rd_reg = 8'h00;
    case (idx)
      `LDM_IDX_CONFIG0: rd_reg[`LDM_BIT_CHIP_EN] = chipEn;
      `LDM_IDX_CONFIG1: rd_reg[5:0] = cfg1;
      `LDM_IDX_LEDCFG0: rd_reg[NG-1:0] = ledCfg;
      `LDM_IDX_STATUS:  rd_reg[5:0] = mode;
      default:          rd_reg = 8'h00;
    endcase
  endfunction

  // Channel to colour bank and module mapping.
  function automatic int bank_of(input int n);
    return n % 3;
  endfunction

  function automatic int module_of(input int n);
    return n / 3;
  endfunction

  // All pins cross into the clock domain through two flip-flops.
  ldm_sync #(.W(7)) uSync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({addressPinHigh, addressPinLow, overTemp, undervoltageLockout, enPin, sdaIn, scl}),
    .q     (pinS)
  );

  // Synchronised pin levels.
  assign sclS  = pinS[0];
  assign sdaS  = pinS[1];
  assign enS   = pinS[2];
  assign uvloS = pinS[3];
  assign otS   = pinS[4];

  // Previous serial line levels for edge and condition detection.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else if (ce) begin
      sclPrev <= sclS;
      sdaPrev <= sdaS;
    end
  end

  // Bus conditions and clock edges.
  assign startCond = sclS & sclPrev & sdaPrev & ~sdaS; // [R16]
  assign stopCond  = sclS & sclPrev & ~sdaPrev & sdaS; // [R16]
  assign sclRise   = sclS & ~sclPrev;
  assign sclFall   = ~sclS & sclPrev;
  assign addrMatch = (shift[7:1] == {`LDM_ADDR_BASE, pinS[6], pinS[5]})
                   || (shift[7:1] == `LDM_ADDR_BCAST); // [R19]
  assign nextIdx   = cfg1[`LDM_BIT_AUTOINC] ? regIdx + 8'h01 : regIdx; // [R22]
  assign rdByte    = rd_reg((iState == ldm_pkg::LDM_I_RD) ? nextIdx : regIdx);
  assign wrSet     = sclFall && bitCnt == 4'h7 && iState == ldm_pkg::LDM_I_WR
                   && !startCond && !stopCond; // [R21]

  // Single register write port; APB wins, a serial write waits one cycle.
  always_comb begin
    apbIdx    = paddr[9:2];
    apbMapped = (paddr[11:10] == 2'h0) && (apbIdx == `LDM_IDX_CONFIG0
              || apbIdx == `LDM_IDX_CONFIG1 || apbIdx == `LDM_IDX_LEDCFG0
              || apbIdx == `LDM_IDX_RESET || apbIdx == `LDM_IDX_STATUS);
    apbWr     = psel && penable && pready && pwrite && apbMapped;
    wrEn      = apbWr || i2cWrPend;
    wrIdx     = apbWr ? apbIdx : i2cWrIdx;
    wrData    = apbWr ? pwdata[7:0] : i2cWrData;
  end

  assign swReset   = wrEn && wrIdx == `LDM_IDX_RESET && wrData == `LDM_SWRESET_KEY;
  assign clearRegs = (state == ldm_pkg::LDM_INIT) || uvloS; // [R9] [R10]

  // Configuration registers; cleared in initialization or while undervoltage is flagged, kept otherwise.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      chipEn <= `LDM_RST_CHIP_EN;
      cfg1   <= `LDM_RST_CONFIG1; // [R5]
      ledCfg <= '0;
    end else if (ce) begin
      if (clearRegs) begin
        chipEn <= `LDM_RST_CHIP_EN; // [R10]
        cfg1   <= `LDM_RST_CONFIG1; // [R5]
        ledCfg <= '0;
      end else if (wrEn) begin // [R6] [R14]
        case (wrIdx)
          `LDM_IDX_CONFIG0: chipEn <= wrData[`LDM_BIT_CHIP_EN];
          `LDM_IDX_CONFIG1: cfg1 <= wrData[5:0];
          `LDM_IDX_LEDCFG0: ledCfg <= wrData[NG-1:0]; // [R2]
          default: ;
        endcase
      end
    end
  end

  // APB slave: one wait state, then a one-cycle pready with data.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready) begin
        prdata  <= {24'h00_0000, rd_reg(apbIdx)};
        pslverr <= !apbMapped;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // Serial byte engine: address, register index, write and read bytes.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      iState     <= ldm_pkg::LDM_I_IDLE;
      bitCnt     <= 4'h0;
      shift      <= 8'h00;
      regIdx     <= 8'h00;
      rw         <= 1'b0;
      mAck       <= 1'b0;
      cmdSeen    <= 1'b0;
      sdaOut     <= 1'b0;
      sdaOutEn_n <= 1'b1;
    end else if (ce) begin
      cmdSeen <= 1'b0;
      if (startCond) begin
        iState     <= ldm_pkg::LDM_I_ADDR; // [R18]
        bitCnt     <= 4'hF; // The start's own clock fall wraps this to zero.
        sdaOutEn_n <= 1'b1;
      end else if (stopCond) begin
        iState     <= ldm_pkg::LDM_I_IDLE;
        sdaOutEn_n <= 1'b1;
      end else if (iState != ldm_pkg::LDM_I_IDLE) begin
        if (sclRise) begin
          if (bitCnt == 4'h8) begin
            mAck <= !sdaS;
          end else if (iState != ldm_pkg::LDM_I_RD) begin
            shift <= {shift[6:0], sdaS}; // [R20]
          end
        end
        if (sclFall) begin // [R15]
          if (bitCnt == 4'h7) begin
            bitCnt <= 4'h8;
            case (iState)
              ldm_pkg::LDM_I_ADDR: begin
                if (addrMatch) begin
                  sdaOutEn_n <= 1'b0; // [R20]
                  rw         <= shift[0];
                  cmdSeen    <= 1'b1;
                end else begin
                  iState <= ldm_pkg::LDM_I_IDLE;
                end
              end
              ldm_pkg::LDM_I_REG: begin
                regIdx     <= shift;
                sdaOutEn_n <= 1'b0;
              end
              ldm_pkg::LDM_I_WR: sdaOutEn_n <= 1'b0;
              default: sdaOutEn_n <= 1'b1;
            endcase
          end else if (bitCnt == 4'h8) begin
            bitCnt     <= 4'h0;
            sdaOutEn_n <= 1'b1;
            case (iState)
              ldm_pkg::LDM_I_ADDR: begin
                if (rw) begin
                  iState     <= ldm_pkg::LDM_I_RD;
                  shift      <= rdByte;
                  sdaOutEn_n <= rdByte[7];
                end else begin
                  iState <= ldm_pkg::LDM_I_REG;
                end
              end
              ldm_pkg::LDM_I_REG: iState <= ldm_pkg::LDM_I_WR;
              ldm_pkg::LDM_I_WR: regIdx <= nextIdx; // [R22]
              ldm_pkg::LDM_I_RD: begin
                if (mAck) begin
                  regIdx     <= nextIdx; // [R22]
                  shift      <= rdByte;
                  sdaOutEn_n <= rdByte[7];
                end else begin
                  iState <= ldm_pkg::LDM_I_IDLE;
                end
              end
              default: iState <= ldm_pkg::LDM_I_IDLE;
            endcase
          end else begin
            bitCnt <= bitCnt + 4'h1;
            if (iState == ldm_pkg::LDM_I_RD) begin
              shift      <= {shift[6:0], 1'b0};
              sdaOutEn_n <= shift[6];
            end
          end
        end
      end
    end
  end

  // Received write byte waits here until the write port takes it.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i2cWrPend <= 1'b0;
      i2cWrIdx  <= 8'h00;
      i2cWrData <= 8'h00;
    end else if (ce) begin
      if (wrSet) begin
        i2cWrPend <= 1'b1;
        i2cWrIdx  <= regIdx;
        i2cWrData <= shift;
      end else if (!apbWr) begin
        i2cWrPend <= 1'b0;
      end
    end
  end

  // Power-save idle interval, counted only while normal and all dark.
  ldm_idle_timer #(.CYCLES(PSAVE_CYCLES), .W(20)) uIdle (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .run   (state == ldm_pkg::LDM_NORMAL && cfg1[`LDM_BIT_PSAVE] && !(|chanActive)), // [R23]
    .done  (idleDone)
  );

  // Operating mode sequence.
  always_comb begin
    next_state = state;
    if (!enS) begin
      next_state = ldm_pkg::LDM_SHUTDOWN; // [R13]
    end else if (uvloS || swReset) begin
      next_state = ldm_pkg::LDM_INIT; // [R9] [R11]
    end else begin
      case (state)
        ldm_pkg::LDM_SHUTDOWN: next_state = ldm_pkg::LDM_INIT; // [R10]
        ldm_pkg::LDM_INIT:     next_state = ldm_pkg::LDM_STANDBY;
        ldm_pkg::LDM_STANDBY: begin
          if (chipEn) next_state = ldm_pkg::LDM_NORMAL; // [R12]
        end
        ldm_pkg::LDM_NORMAL: begin
          if (!chipEn) next_state = ldm_pkg::LDM_STANDBY; // [R14]
          else if (otS) next_state = ldm_pkg::LDM_THERMAL; // [R8]
          else if (idleDone) next_state = ldm_pkg::LDM_PSAVE; // [R4]
        end
        ldm_pkg::LDM_PSAVE: begin
          if (!chipEn) next_state = ldm_pkg::LDM_STANDBY;
          else if (otS) next_state = ldm_pkg::LDM_THERMAL;
          else if (cmdSeen) next_state = ldm_pkg::LDM_NORMAL; // [R7]
        end
        ldm_pkg::LDM_THERMAL: begin
          if (!chipEn) next_state = ldm_pkg::LDM_STANDBY;
          else if (!otS) next_state = ldm_pkg::LDM_NORMAL; // [R8]
        end
        default: next_state = ldm_pkg::LDM_SHUTDOWN;
      endcase
    end
  end

  // Mode register, the controls derived from it, and the registered config1 field outputs.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state          <= ldm_pkg::LDM_SHUTDOWN; // [R13]
      mode           <= ldm_pkg::LDM_SHUTDOWN;
      coreReset      <= 1'b0;
      analogOn       <= 1'b0;
      outEnable      <= 1'b0;
      maxCurrentHigh <= 1'b0;
      fullScaleUa    <= `LDM_IMAX_LO_UA;
      logScale       <= 1'b0;
      ditherOn       <= 1'b0;
    end else if (ce) begin
      state          <= next_state;
      mode           <= next_state;
      coreReset      <= next_state == ldm_pkg::LDM_INIT; // [R9]
      analogOn       <= next_state == ldm_pkg::LDM_NORMAL; // [R6]
      outEnable      <= next_state == ldm_pkg::LDM_NORMAL && !cfg1[`LDM_BIT_GOFF]; // [R12] [R14]
      maxCurrentHigh <= cfg1[`LDM_BIT_MAXCUR];
      fullScaleUa    <= cfg1[`LDM_BIT_MAXCUR] ? `LDM_IMAX_HI_UA : `LDM_IMAX_LO_UA; // [R3]
      logScale       <= cfg1[`LDM_BIT_LOG];
      ditherOn       <= cfg1[`LDM_BIT_DITHER];
    end
  end

  // Per-channel bank code and module group select.
  for (genvar n = 0; n < NCH; n++) begin : gCh
    assign grpSel[n]         = ledCfg[module_of(n)]; // [R1]
    assign bankCode[2*n +: 2] = 2'(bank_of(n)); // [R1]
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      moduleGroupSelect <= '0;
      chanBank          <= '0;
    end else if (ce) begin
      moduleGroupSelect <= grpSel;
      chanBank          <= bankCode;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Checks on the mode sequence and the serial port.
  shutdown_on_en_a: assert property (ce && !enS |=> state == ldm_pkg::LDM_SHUTDOWN) // [R13]
    else $error("enable low did not shut down");
  undervoltage_lockout_init_a: assert property (ce && enS && uvloS |=> state == ldm_pkg::LDM_INIT && coreReset) // [R9]
    else $error("undervoltage did not hold initialization");
  sw_reset_a: assert property (ce && enS && swReset |=> mode == ldm_pkg::LDM_INIT) // [R11]
    else $error("reset key did not initialize");
  init_defaults_a: assert property (ce && state == ldm_pkg::LDM_INIT |=> cfg1[`LDM_BIT_PSAVE] && !chipEn) // [R5]
    else $error("initialization left non-default registers");
  chip_enable_a: assert property (ce && enS && !uvloS && !swReset && chipEn
    && state == ldm_pkg::LDM_STANDBY |=> state == ldm_pkg::LDM_NORMAL ##1 (!ce || analogOn || state != ldm_pkg::LDM_NORMAL)) // [R12]
    else $error("chip enable did not reach normal");
  psave_wake_a: assert property (ce && enS && !uvloS && !swReset && chipEn && !otS && cmdSeen
    && state == ldm_pkg::LDM_PSAVE |=> state == ldm_pkg::LDM_NORMAL) // [R7]
    else $error("serial command did not wake power-save");
  psave_analog_a: assert property (state == ldm_pkg::LDM_PSAVE |-> !analogOn && !outEnable) // [R6]
    else $error("analog active in power-save");
  thermal_off_a: assert property (ce && enS && !uvloS && !swReset && chipEn && otS
    && state == ldm_pkg::LDM_NORMAL |=> state == ldm_pkg::LDM_THERMAL ##1 (!ce || !outEnable)) // [R8]
    else $error("overtemperature did not shut outputs");
  sda_stable_a: assert property (ce && sclS && sclPrev && !startCond && !stopCond |=> $stable(sdaOutEn_n)) // [R15]
    else $error("data changed while clock high");
  auto_incr_a: assert property (ce && sclFall && !startCond && !stopCond && bitCnt == 4'h8
    && iState == ldm_pkg::LDM_I_WR && cfg1[`LDM_BIT_AUTOINC] |=> regIdx == $past(regIdx) + 8'h01) // [R22]
    else $error("register index did not advance");
endmodule
`default_nettype wire

// File: test/ldm_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
// Two-wire bus master model; clock stands high between frames.
module ldm_i2c_master (
  // Bench clock, used only to keep bus edges off its rising edge.
  input  wire logic clk,
  // Bus lines.
  output var  logic scl,
  output var  logic sda,
  input  wire logic line
);
  // Bus starts idle, both lines released high.
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  // Start or repeated start: data falls while clock is high.
  task automatic start();
    @(negedge clk);
    #100 sda = 1'b1;
    #100 scl = 1'b1;
    #200 sda = 1'b0;
    #200 scl = 1'b0;
  endtask
  // Stop: data rises while clock is high, which frees the bus.
  task automatic stop();
    #100 sda = 1'b0;
    #100 scl = 1'b1;
    #200 sda = 1'b1;
    #200;
  endtask
  // One bit; data moves only in mid low phase, sampled while clock is high.
  task automatic bit1(input logic b, output logic r);
    #100 sda = b;
    #100 scl = 1'b1;
    #100 r = line;
    #100 scl = 1'b0;
  endtask
  // Byte out, most significant bit first, then the acknowledge slot.
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(d[i], r);
    bit1(1'b1, r);
    ack = !r;
  endtask
  // Byte in, then acknowledge or not.
  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
    bit1(nack, r);
  endtask
endmodule
`default_nettype wire

// File: test/ldm_mode_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ldm_mode_ctrl_tb;
  logic        clk, rst_n, ce, psel, penable, pwrite, enPin, undervoltageLockout, overTemp;
  logic        addressPinLow, addressPinHigh, scl, mSda, sdaOut, sdaOutEn_n, pready, pslverr;
  logic        coreReset, analogOn, outEnable, maxCurrentHigh, logScale, ditherOn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [23:0] chanActive, moduleGroupSelect;
  logic [47:0] chanBank;
  logic [5:0]  mode;
  logic [15:0] fullScaleUa;
  int          fails, comparisons;
  // Open-drain data line with pull-up.
  wire logic   sdaLine = (sdaOutEn_n ? 1'b1 : sdaOut) & mSda;
  ldm_mode_ctrl #(.NCH(24), .PSAVE_CYCLES(50)) dut (
    .clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOutEn_n(sdaOutEn_n), .enPin(enPin),
    .undervoltageLockout(undervoltageLockout), .overTemp(overTemp),
    .addressPinLow(addressPinLow), .addressPinHigh(addressPinHigh), .chanActive(chanActive),
    .mode(mode), .coreReset(coreReset), .analogOn(analogOn), .outEnable(outEnable),
    .maxCurrentHigh(maxCurrentHigh), .fullScaleUa(fullScaleUa), .logScale(logScale),
    .ditherOn(ditherOn), .moduleGroupSelect(moduleGroupSelect), .chanBank(chanBank));
  ldm_i2c_master m (.clk(clk), .scl(scl), .sda(mSda), .line(sdaLine));
  // Clock generator.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string s, input logic [47:0] e, input logic [47:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // APB transfer: setup, access, hold until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] i, d, output logic [31:0] r,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrReg(input logic [7:0] i, d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, i, d, r, e);
  endtask
  task automatic rdChk(input string s, input logic [7:0] i, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, i, 8'h00, r, e);
    chk(s, x, r);
  endtask
  task automatic tDefaults();
    logic [31:0] r;
    logic        e;
    cyc(6);
    chk("mode", 6'h04, mode);
    for (int n = 0; n < 24; n++) chk("bank", n % 3, chanBank[2*n+:2]);
    chk("fullScale", 16'h639C, fullScaleUa);
    chk("maxCurrent", 1'b0, maxCurrentHigh);
    chk("logScale", 1'b1, logScale);
    chk("dither", 1'b1, ditherOn);
    chk("sdaOut", 1'b0, sdaOut);
    rdChk("config1", 8'h01, 32'h0000_003C);
    chk("outEnable", 1'b0, outEnable);
    apb(1'b0, 8'h03, 8'h00, r, e);
    chk("unmapped", 1'b1, e);
  endtask
  task automatic tModes();
    wrReg(8'h00, 8'h40);
    cyc(4);
    chk("normal", 6'h08, mode);
    chk("outEnable", 1'b1, outEnable);
    wrReg(8'h01, 8'h3E);
    wrReg(8'h02, 8'h05);
    cyc(4);
    chk("fullScale", 16'h88B8, fullScaleUa);
    chk("maxCurrent", 1'b1, maxCurrentHigh);
    chk("groups", 24'h00_01C7, moduleGroupSelect);
    @(posedge clk);
    ce <= 1'b0;
    overTemp <= 1'b1;
    cyc(6);
    chk("frozen", 6'h08, mode);
    @(posedge clk);
    ce <= 1'b1;
    cyc(6);
    chk("thermal", 6'h20, mode);
    chk("outEnable", 1'b0, outEnable);
    @(posedge clk);
    overTemp <= 1'b0;
    cyc(6);
    chk("cooled", 6'h08, mode);
    wrReg(8'h00, 8'h00);
    cyc(4);
    chk("standby", 6'h04, mode);
    rdChk("kept", 8'h02, 32'h0000_0005);
  endtask
  task automatic tPsave();
    logic a;
    wrReg(8'h00, 8'h40);
    @(posedge clk);
    chanActive <= 24'h80_0000;
    cyc(80);
    chk("busy", 6'h08, mode);
    @(posedge clk);
    chanActive <= 24'h00_0000;
    cyc(40);
    chk("counting", 6'h08, mode);
    cyc(20);
    chk("psave", 6'h10, mode);
    chk("analogOn", 1'b0, analogOn);
    rdChk("config0", 8'h00, 32'h0000_0040);
    m.start();
    m.wr(8'h54, a);
    m.stop();
    chk("ack", 1'b1, a);
    chk("wake", 6'h08, mode);
  endtask
  task automatic tSerial();
    logic       a;
    logic [7:0] d;
    m.start();
    m.wr(8'h54, a);
    m.wr(8'h01, a);
    m.wr(8'h2A, a);
    m.wr(8'h03, a);
    m.stop();
    rdChk("config1", 8'h01, 32'h0000_002A);
    chk("dither", 1'b0, ditherOn);
    rdChk("ledcfg", 8'h02, 32'h0000_0003);
    m.start();
    m.wr(8'h78, a);
    chk("bcast", 1'b1, a);
    m.wr(8'h01, a);
    m.start();
    m.wr(8'h79, a);
    m.rd(1'b0, d);
    chk("read1", 8'h2A, d);
    m.rd(1'b1, d);
    chk("read2", 8'h03, d);
    m.stop();
    m.start();
    m.wr(8'h50, a);
    m.stop();
    chk("foreign", 1'b0, a);
  endtask
  task automatic tResets();
    wrReg(8'h30, 8'hFF);
    rdChk("config1", 8'h01, 32'h0000_003C);
    rdChk("ledcfg", 8'h02, 32'h0000_0000);
    @(posedge clk);
    undervoltageLockout <= 1'b1;
    cyc(10);
    chk("undervoltage_lockout", 6'h02, mode);
    chk("coreReset", 1'b1, coreReset);
    @(posedge clk);
    undervoltageLockout <= 1'b0;
    enPin <= 1'b0;
    cyc(6);
    chk("shutdown", 6'h01, mode);
    @(posedge clk);
    enPin <= 1'b1;
    cyc(8);
    chk("restart", 6'h04, mode);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {undervoltageLockout, overTemp, addressPinLow, chanActive} = '0;
    enPin = 1'b1;
    ce = 1'b1;
    addressPinHigh = 1'b1;
    fails = 0;
    comparisons = 0;
    cyc(3);
    rst_n <= 1'b1;
    tDefaults();
    tModes();
    tPsave();
    tSerial();
    tResets();
    tally_and_finish();
  end
  // Watchdog against a hang.
  initial begin
    #1_000_000;
    fails++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
